// [verilog/ddr3_dev.sv]
// Device end: bank/row tracking, precharge timing and read bursts.
// Assumes the controller keeps command spacing; DQ is one beat per half
// cycle, presented here as one beat per clock with a phase flag.
`timescale 1ns/1ps
`default_nettype none
module ddr3_dev #(
  parameter int NUM_BANKS = ddr3_pkg::NUM_BANKS,
  parameter int T_RP_CYC = ddr3_pkg::T_RP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ddr3_link_if.dev link,
  input wire logic [1:0] bl_mode_i,
  input wire logic [ddr3_pkg::LAT_W-1:0] al_i,
  input wire logic [ddr3_pkg::LAT_W-1:0] cl_i,
  input wire logic dll_locked_i,
  output logic [NUM_BANKS-1:0] bank_open_o,
  output logic [NUM_BANKS-1:0] bank_prechg_o,
  output logic rd_miss_o,
  output logic [ddr3_pkg::COL_W-1:0] rd_col_o
);
  localparam int LAT_MAX = 2 ** ddr3_pkg::LAT_W * 2;
  localparam int LC_W = ddr3_pkg::LAT_W + 1;
  localparam logic [ddr3_pkg::TIMER_W-1:0] TRP =
    ddr3_pkg::TIMER_W'(T_RP_CYC);

  logic [NUM_BANKS-1:0] open_r;
  logic [NUM_BANKS-1:0] open_nxt;
  logic [ddr3_pkg::ROW_W-1:0] row_r [NUM_BANKS];
  logic [ddr3_pkg::ROW_W-1:0] row_nxt [NUM_BANKS];
  logic [ddr3_pkg::TIMER_W-1:0] tmr_r [NUM_BANKS];
  logic [ddr3_pkg::TIMER_W-1:0] tmr_nxt [NUM_BANKS];
  logic [NUM_BANKS-1:0] pend_r;
  logic [NUM_BANKS-1:0] pend_nxt;

  logic [LAT_MAX-1:0] q_go_r;
  logic [LAT_MAX-1:0] q_go_nxt;
  logic [LAT_MAX-1:0] q_bl8_r;
  logic [LAT_MAX-1:0] q_bl8_nxt;
  logic [2:0] beats_r;
  logic [2:0] beats_nxt;
  logic [ddr3_pkg::DQ_W-1:0] dq_r;
  logic [ddr3_pkg::DQ_W-1:0] dq_nxt;
  logic oe_r;
  logic oe_nxt;
  logic ph_r;
  logic ph_nxt;
  logic miss_r;
  logic miss_nxt;
  logic [ddr3_pkg::COL_W-1:0] col_r;
  logic [ddr3_pkg::COL_W-1:0] col_nxt;
  logic [ddr3_pkg::COL_W-1:0] col_now;
  logic [LC_W-1:0] rl;
  logic is_rd;
  logic bl8;
  logic hit;
  logic pre_all;
  logic launch;

  assign is_rd = link.cmd == ddr3_pkg::CMD_RD;
  assign pre_all = link.addr[ddr3_pkg::AP_BIT];
  assign rl = LC_W'(al_i) + LC_W'(cl_i);
  // Only A0..A9 form the column, so A12 never leaks into it.
  assign col_now = link.addr[ddr3_pkg::COL_W-1:0];
  assign hit = open_r[link.ba];
  // A read with no lock or no latency is dropped rather than queued.
  assign launch = hit && dll_locked_i && rl != '0;
  always_comb begin
    unique case (bl_mode_i)
      ddr3_pkg::BL_FIXED8: bl8 = 1'b1;
      ddr3_pkg::BL_OTF: bl8 = link.addr[ddr3_pkg::BC_BIT];
      default: bl8 = 1'b0;
    endcase
  end

  // A later precharge reloads the timer, so the newest one sets tRP.
  always_comb begin
    open_nxt = open_r;
    pend_nxt = pend_r;
    for (int b = 0; b < NUM_BANKS; b++) begin
      row_nxt[b] = row_r[b];
      tmr_nxt[b] = (tmr_r[b] != '0) ? tmr_r[b] - 1'b1 : tmr_r[b];
      if (tmr_r[b] == ddr3_pkg::TIMER_W'(1)) pend_nxt[b] = 1'b0;
      if (link.cmd == ddr3_pkg::CMD_PRE &&
          (pre_all || link.ba == ddr3_pkg::BANK_W'(b))) begin
        // Idle or still precharging banks take it too; restart.
        open_nxt[b] = 1'b0;
        tmr_nxt[b] = TRP;
        pend_nxt[b] = 1'b1;
      end
      if (link.cmd == ddr3_pkg::CMD_ACT &&
          link.ba == ddr3_pkg::BANK_W'(b)) begin
        open_nxt[b] = 1'b1;
        row_nxt[b] = link.addr[ddr3_pkg::ROW_W-1:0];
      end
    end
  end

  // Read requests shift toward the bus; position 0 launches data.
  always_comb begin
    q_go_nxt = {1'b0, q_go_r[LAT_MAX-1:1]};
    q_bl8_nxt = {1'b0, q_bl8_r[LAT_MAX-1:1]};
    miss_nxt = 1'b0;
    col_nxt = col_r;
    if (is_rd) begin
      miss_nxt = !hit;
      col_nxt = col_now;
      // Timing is only honoured with DLL locked; else no data.
      if (launch) begin
        q_go_nxt[rl - 1'b1] = 1'b1;
        q_bl8_nxt[rl - 1'b1] = bl8;
      end
    end
  end

  // One beat per clock with a phase flag stands in for both strobe edges,
  // so a burst of eight beats spans eight clocks here.
  always_comb begin
    beats_nxt = beats_r;
    oe_nxt = oe_r;
    ph_nxt = 1'b0;
    dq_nxt = dq_r;
    if (q_go_r[0]) begin
      beats_nxt = q_bl8_r[0] ? 3'(ddr3_pkg::CYC_BL8 * 2 - 1) :
        3'(ddr3_pkg::CYC_BC4 * 2 - 1);
      oe_nxt = 1'b1;
      dq_nxt = ddr3_pkg::DQ_W'(col_r);
    end else if (beats_r != '0) begin
      beats_nxt = beats_r - 1'b1;
      ph_nxt = !ph_r;
      dq_nxt = dq_r + 1'b1;
    end else begin
      oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      open_r <= '0;
      pend_r <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        row_r[b] <= '0;
        tmr_r[b] <= '0;
      end
    end else begin
      open_r <= open_nxt;
      pend_r <= pend_nxt;
      for (int b = 0; b < NUM_BANKS; b++) begin
        row_r[b] <= row_nxt[b];
        tmr_r[b] <= tmr_nxt[b];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_go_r <= '0;
      q_bl8_r <= '0;
      miss_r <= 1'b0;
      col_r <= '0;
    end else begin
      q_go_r <= q_go_nxt;
      q_bl8_r <= q_bl8_nxt;
      miss_r <= miss_nxt;
      col_r <= col_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      beats_r <= '0;
      dq_r <= '0;
      oe_r <= 1'b0;
      ph_r <= 1'b0;
    end else begin
      beats_r <= beats_nxt;
      dq_r <= dq_nxt;
      oe_r <= oe_nxt;
      ph_r <= ph_nxt;
    end
  end

  assign link.dq = dq_r;
  assign link.dq_oe = oe_r;
  assign link.dqs_valid = oe_r;
  assign link.dqs_phase = ph_r;
  assign bank_open_o = open_r;
  assign bank_prechg_o = pend_r;
  assign rd_miss_o = miss_r;
  assign rd_col_o = col_r;
endmodule
`default_nettype wire

// [verilog/ddr3_pkg.sv]
// Shared constants and types for the bank/row and read burst link.
// Assumes both ends run on one 250 MHz clock with an active high reset.
package ddr3_pkg;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int ADDR_W = 13;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int DQ_W = 16;
  localparam int BC_BIT = 12;
  localparam int AP_BIT = 10;
  localparam int LAT_W = 5;
  localparam int BEATS_BL8 = 8;
  localparam int BEATS_BC4 = 4;
  localparam int CYC_BL8 = BEATS_BL8 / 2;
  localparam int CYC_BC4 = BEATS_BC4 / 2;
  localparam int T_RP_NS = 15;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int T_RP_CYC = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) /
    CLK_PERIOD_PS;
  localparam int TIMER_W = 8;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_PRE = 4'h2,
    CMD_RD = 4'h3,
    CMD_WR = 4'h4
  } cmd_e;
endpackage

// [verilog/ddr3_link_if.sv]
// Command, address and read data link between controller and device.
// Assumes the testbench joins both modports on a shared clock.
`timescale 1ns/1ps
`default_nettype none
interface ddr3_link_if;
  ddr3_pkg::cmd_e cmd;
  logic [ddr3_pkg::BANK_W-1:0] ba;
  logic [ddr3_pkg::ADDR_W-1:0] addr;
  logic [ddr3_pkg::DQ_W-1:0] dq;
  logic dq_oe;
  logic dqs_valid;
  logic dqs_phase;
  modport ctrl (
    output cmd,
    output ba,
    output addr,
    input dq,
    input dq_oe,
    input dqs_valid,
    input dqs_phase
  );
  modport dev (
    input cmd,
    input ba,
    input addr,
    output dq,
    output dq_oe,
    output dqs_valid,
    output dqs_phase
  );
endinterface
`default_nettype wire

// [verilog/ddr3_ctrl.sv]
// Controller end: issues ACT, PRE and READ on request, keeping spacing.
// Assumes one user request at a time, taken while ready_o is high.
`timescale 1ns/1ps
`default_nettype none
module ddr3_ctrl #(
  parameter int NUM_BANKS = ddr3_pkg::NUM_BANKS,
  parameter int T_RP_CYC = ddr3_pkg::T_RP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ddr3_link_if.ctrl link,
  input wire logic req_i,
  input wire logic [ddr3_pkg::BANK_W-1:0] bank_i,
  input wire logic [ddr3_pkg::ROW_W-1:0] row_i,
  input wire logic [ddr3_pkg::COL_W-1:0] col_i,
  input wire logic bl8_i,
  input wire logic dll_locked_i,
  output logic ready_o,
  output logic [ddr3_pkg::DQ_W-1:0] rdata_o,
  output logic rvalid_o
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PRE = 4'h2,
    ST_ACT = 4'h4,
    ST_RD = 4'h8
  } st_e;
  localparam logic [ddr3_pkg::TIMER_W-1:0] TRP =
    ddr3_pkg::TIMER_W'(T_RP_CYC);
  st_e st_r, st_nxt;
  logic [NUM_BANKS-1:0] open_r, open_nxt;
  logic [ddr3_pkg::ROW_W-1:0] row_r [NUM_BANKS];
  logic [ddr3_pkg::ROW_W-1:0] row_nxt [NUM_BANKS];
  logic [ddr3_pkg::TIMER_W-1:0] wait_r, wait_nxt;
  ddr3_pkg::cmd_e cmd_r, cmd_nxt;
  logic [ddr3_pkg::BANK_W-1:0] ba_r, ba_nxt;
  logic [ddr3_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [ddr3_pkg::ROW_W-1:0] trow_r, trow_nxt;
  logic [ddr3_pkg::COL_W-1:0] tcol_r, tcol_nxt;
  logic tbl8_r, tbl8_nxt, rdy_r, rdy_nxt;
  logic [ddr3_pkg::DQ_W-1:0] rd_r;
  logic rv_r, rv_nxt;

  always_comb begin
    st_nxt = st_r;
    open_nxt = open_r;
    wait_nxt = (wait_r != '0) ? wait_r - 1'b1 : wait_r;
    cmd_nxt = ddr3_pkg::CMD_NOP;
    ba_nxt = ba_r;
    addr_nxt = addr_r;
    trow_nxt = trow_r;
    tcol_nxt = tcol_r;
    tbl8_nxt = tbl8_r;
    rdy_nxt = 1'b0;
    // Captured data is trusted only while the DLL is locked.
    rv_nxt = link.dqs_valid && dll_locked_i;
    for (int b = 0; b < NUM_BANKS; b++) row_nxt[b] = row_r[b];
    unique case (st_r)
      ST_IDLE: begin
        rdy_nxt = 1'b1;
        if (req_i && rdy_r && dll_locked_i) begin
          rdy_nxt = 1'b0;
          ba_nxt = bank_i;
          trow_nxt = row_i;
          tcol_nxt = col_i;
          tbl8_nxt = bl8_i;
          if (!open_r[bank_i]) st_nxt = ST_ACT;
          else if (row_r[bank_i] != row_i) st_nxt = ST_PRE;
          else st_nxt = ST_RD;
        end
      end
      ST_PRE: begin
        cmd_nxt = ddr3_pkg::CMD_PRE;
        addr_nxt = '0;
        open_nxt[ba_r] = 1'b0;
        wait_nxt = TRP;
        st_nxt = ST_ACT;
      end
      ST_ACT: if (wait_r == '0) begin
        cmd_nxt = ddr3_pkg::CMD_ACT;
        addr_nxt = trow_r;
        open_nxt[ba_r] = 1'b1;
        row_nxt[ba_r] = trow_r;
        st_nxt = ST_RD;
      end
      ST_RD: begin
        cmd_nxt = ddr3_pkg::CMD_RD;
        addr_nxt = '0;
        addr_nxt[ddr3_pkg::COL_W-1:0] = tcol_r;
        addr_nxt[ddr3_pkg::BC_BIT] = tbl8_r;
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      open_r <= '0;
      wait_r <= '0;
      cmd_r <= ddr3_pkg::CMD_NOP;
      ba_r <= '0;
      addr_r <= '0;
      trow_r <= '0;
      tcol_r <= '0;
      tbl8_r <= 1'b0;
      rdy_r <= 1'b0;
      rd_r <= '0;
      rv_r <= 1'b0;
      for (int b = 0; b < NUM_BANKS; b++) row_r[b] <= '0;
    end else begin
      st_r <= st_nxt;
      open_r <= open_nxt;
      wait_r <= wait_nxt;
      cmd_r <= cmd_nxt;
      ba_r <= ba_nxt;
      addr_r <= addr_nxt;
      trow_r <= trow_nxt;
      tcol_r <= tcol_nxt;
      tbl8_r <= tbl8_nxt;
      rdy_r <= rdy_nxt;
      rd_r <= link.dq;
      rv_r <= rv_nxt;
      for (int b = 0; b < NUM_BANKS; b++) row_r[b] <= row_nxt[b];
    end
  end

  assign link.cmd = cmd_r;
  assign link.ba = ba_r;
  assign link.addr = addr_r;
  assign ready_o = rdy_r;
  assign rdata_o = rd_r;
  assign rvalid_o = rv_r;
endmodule
`default_nettype wire

// [test/ddr3_link_checker.sv]
// Assertions on the command and read data link between the two ends.
// Assumes one clock, async active high reset and a fixed read latency.
`timescale 1ns/1ps
`default_nettype none
module ddr3_link_checker #(
  parameter int RL_CYC = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input var ddr3_pkg::cmd_e cmd,
  input wire logic [ddr3_pkg::BANK_W-1:0] ba,
  input wire logic [ddr3_pkg::ADDR_W-1:0] addr,
  input wire logic [ddr3_pkg::DQ_W-1:0] dq,
  input wire logic dq_oe,
  input wire logic dqs_valid,
  input wire logic dqs_phase
);
  localparam int RL1 = RL_CYC + 1;
  localparam int RL2 = RL_CYC + 2;
  logic [ddr3_pkg::NUM_BANKS-1:0] open_r;
  logic [ddr3_pkg::NUM_BANKS-1:0] open_nxt;
  always_comb begin
    open_nxt = open_r;
    if (cmd == ddr3_pkg::CMD_ACT) begin
      open_nxt[ba] = 1'b1;
    end else if (cmd == ddr3_pkg::CMD_PRE) begin
      if (addr[ddr3_pkg::AP_BIT]) begin
        open_nxt = '0;
      end else begin
        open_nxt[ba] = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      open_r <= '0;
    end else begin
      open_r <= open_nxt;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_bc4;
    dq_oe [*4] ##1 !dq_oe;
  endsequence
  sequence s_bl8;
    dq_oe [*8] ##1 !dq_oe;
  endsequence
  a_strobe_valid: assert property (dqs_valid == dq_oe)
    else $error("strobe valid differs from data enable");
  a_burst_len: assert property ($rose(dq_oe) |-> s_bc4 or s_bl8)
    else $error("burst is neither four nor eight beats");
  a_first_phase: assert property ($rose(dq_oe) |-> !dqs_phase)
    else $error("burst does not start on rising phase");
  a_beat_step: assert property (dq_oe && $past(dq_oe) |->
    dq == $past(dq) + 16'h0001 && dqs_phase != $past(dqs_phase))
    else $error("beat data or phase did not advance");
  a_read_latency: assert property ($rose(dq_oe) |->
    $past(cmd, RL1) == ddr3_pkg::CMD_RD || $past(cmd, RL2) == ddr3_pkg::CMD_RD)
    else $error("burst not at read latency");
  a_pre_gap: assert property (cmd == ddr3_pkg::CMD_PRE |=>
    (cmd != ddr3_pkg::CMD_ACT) [*3])
    else $error("activate inside precharge time");
  a_rd_open: assert property (
    cmd == ddr3_pkg::CMD_RD |-> open_r[ba])
    else $error("read to idle bank");
  a_act_closed: assert property (
    cmd == ddr3_pkg::CMD_ACT |-> !open_r[ba])
    else $error("activate on bank with open row");
endmodule
`default_nettype wire

// [test/ddr3_bank_row_and_read_burst_tb_top.sv]
// Testbench joining controller and device ends through the link.
// Assumes fixed AL and CL; expected beats queue up as each read is sent.
`timescale 1ns/1ps
`default_nettype none
module ddr3_bank_row_and_read_burst_tb_top;
  localparam int AL = 2;
  localparam int CL = 5;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic [2:0] bank_i = 3'h0;
  logic [12:0] row_i = 13'h0000;
  logic [9:0] col_i = 10'h000;
  logic bl8_i = 1'b0;
  logic dll_i = 1'b1;
  logic [1:0] mode_i = 2'h1;
  logic ready_o;
  logic rvalid_o;
  logic rd_miss_o;
  logic [15:0] rdata_o;
  logic [7:0] open_o;
  logic [7:0] prechg_o;
  logic [7:0] exp_open = 8'h00;
  logic [7:0] saw_pre = 8'h00;
  logic [9:0] col_o;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h7988;
  int err_count = 0;
  int checks_done = 0;
  always #2 clk_i = ~clk_i;
  ddr3_link_if link();
  ddr3_ctrl u_ddr3_ctrl (.clk_i(clk_i), .rst_i(rst_i), .link(link.ctrl),
    .req_i(req_i), .bank_i(bank_i), .row_i(row_i), .col_i(col_i),
    .bl8_i(bl8_i), .dll_locked_i(dll_i), .ready_o(ready_o),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o));
  ddr3_dev u_ddr3_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link.dev),
    .bl_mode_i(mode_i), .al_i(5'(AL)), .cl_i(5'(CL)), .dll_locked_i(dll_i),
    .bank_open_o(open_o), .bank_prechg_o(prechg_o), .rd_miss_o(rd_miss_o),
    .rd_col_o(col_o));
  ddr3_link_checker #(.RL_CYC(AL + CL)) u_ddr3_link_checker (.clk_i(clk_i),
    .rst_i(rst_i), .cmd(link.cmd), .ba(link.ba), .addr(link.addr),
    .dq(link.dq), .dq_oe(link.dq_oe), .dqs_valid(link.dqs_valid),
    .dqs_phase(link.dqs_phase));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Waiting for the queue as well as ready keeps late beats in one read.
  task automatic wait_idle();
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge clk_i);
      if (ready_o === 1'b1 && exp_q.size() == 0) break;
    end
    if (i == 300) begin
      check(1'b0, "hang");
      complete_run();
    end
  endtask
  task automatic rd(input logic [2:0] b, input logic [12:0] r,
    input logic [9:0] c, input logic l8);
    int n;
    wait_idle();
    n = (mode_i == 2'h0 || (mode_i == 2'h1 && l8)) ? 8 : 4;
    for (int k = 0; k < n; k++) exp_q.push_back({6'h00, c} + 16'(k));
    @(posedge clk_i);
    req_i <= 1'b1;
    bank_i <= b;
    row_i <= r;
    col_i <= c;
    bl8_i <= l8;
    @(posedge clk_i);
    req_i <= 1'b0;
    exp_open[b] = 1'b1;
    @(posedge clk_i);
    wait_idle();
    check(open_o === exp_open, "bank state");
    check(col_o === c, "read column");
  endtask
  always @(negedge clk_i) begin
    saw_pre = saw_pre | prechg_o;
    if (rd_miss_o !== 1'b0) check(1'b0, "read miss");
    if (rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "extra beat");
      else check(rdata_o === exp_q.pop_front(), "read data");
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(3'h0, 13'h0005, 10'h010, 1'b1);
    for (int m = 0; m < 4; m++) begin
      for (int l = 0; l < 2; l++) begin
        @(posedge clk_i);
        mode_i <= 2'(m);
        rd(3'h0, 13'h0005, 10'(16 * m + l), 1'(l));
      end
    end
    $display("test burst modes done");
    saw_pre = 8'h00;
    rd(3'h0, 13'h0006, 10'h3F8, 1'b1);
    check(saw_pre[0] === 1'b1, "precharge seen");
    $display("test row conflict done");
    for (int j = 0; j < 6; j++) begin
      seed = xs(seed);
      rd(seed[2:0], seed[15:3], seed[25:16], seed[26]);
    end
    $display("test random reads done");
    @(posedge clk_i);
    dll_i <= 1'b0;
    req_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    req_i <= 1'b0;
    dll_i <= 1'b1;
    @(negedge clk_i);
    check(col_o === seed[25:16], "read while unlocked");
    @(posedge clk_i);
    col_i <= 10'h155;
    req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    @(posedge clk_i);
    dll_i <= 1'b0;
    for (int j = 0; j < 20; j++) begin
      @(negedge clk_i);
      check(link.dq_oe === 1'b0, "burst while unlocked");
    end
    @(posedge clk_i);
    dll_i <= 1'b1;
    @(negedge clk_i);
    check(col_o === 10'h155, "unlocked read column");
    $display("test unlocked done");
    complete_run();
  end
endmodule
`default_nettype wire
